/* hdl/output_if_cfg.svh */
/*
 Constants of the output interface and power-down register group: register
 offsets, field positions, reset values and timing counts.
 Assumes inclusion by bare name from every design file that needs them.
*/
// Function
// (RQ1) Mapper bits 7:5 code 001 two-lane 18/14, 010 two-lane 20/16, 011 one-lane, 100 half-lane.
// (RQ2) A written mapper value takes effect only when the fuse load command is issued.
// (RQ3) Host writes the interface register and fuse load first; the load drops prior writes.
// (RQ4) After the initial reset the default variant loads from fuses with no host action.
// (RQ5) Mapper and lane-select fields read 000 until written, although a fuse default is in force.
// (RQ6) The lane select field codes 011 two-lane, 100 one-lane and 101 half-lane.
// (RQ7) Lane select replaces the default mode only while the override enable in bit 3 is set.
// (RQ8) On a mode change the host rewrites the buffer disable and related clock registers.
// (RQ9) Power bit 5 switches the sampling clock buffer off when 1.
// (RQ10) Power bit 4 switches the reference gain amplifier off when 1.
// (RQ11) Power bit 2 switches channel A off when 1.
// (RQ12) Power bit 1 switches channel B off when 1.
// (RQ13) Power bit 0 enters whole-chip sleep, where only blocks the mask does not exempt go off; the code turns bandgap off only when mask bit 1 is set.
// (RQ14) Each of the 24 buffer disable bits in three registers turns one buffer off when 1.
// (RQ15) Host writes zero to interface bit 4 and to power bits 7, 6 and 3.
`ifndef OUTPUT_IF_CFG_SVH
`define OUTPUT_IF_CFG_SVH

`define ADDR_SOFT_RESET  7'h00
`define ADDR_IF_CFG      7'h07
`define ADDR_PWR         7'h08
`define ADDR_OBD0        7'h0A
`define ADDR_OBD1        7'h0B
`define ADDR_OBD2        7'h0C
`define ADDR_FUSE_CMD    7'h13

`define IF_MAPPER_MSB    7
`define IF_MAPPER_LSB    5
`define IF_OVR_EN_BIT    3
`define IF_SEL_MSB       2
`define IF_SEL_LSB       0

`define PWR_CLKBUF_BIT   5
`define PWR_REFAMP_BIT   4
`define PWR_CHA_BIT      2
`define PWR_CHB_BIT      1
`define PWR_GLOBAL_BIT   0

`define MASK_CLKBUF_BIT  3
`define MASK_REFAMP_BIT  2
`define MASK_BG_BIT      1

`define REG_RESET        8'h00
`define FUSE_LOAD_CYCLES 16
`define FUSE_MAPPER_DEF  3'h2
`define FUSE_MODE_DEF    3'h3

`define FRAME_BITS       5'h10
`define ADDR_PHASE_BITS  5'h08

`endif

/* hdl/output_if_pkg.sv */
/*
 Types of the output interface and power-down register group.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package output_if_pkg;
   typedef enum logic [2:0] {
      LANE_TWO  = 3'h3,
      LANE_ONE  = 3'h4,
      LANE_HALF = 3'h5
   } lane_mode_e;
   typedef enum logic [2:0] {
      MAP_TWO_18_14 = 3'h1,
      MAP_TWO_20_16 = 3'h2,
      MAP_ONE       = 3'h3,
      MAP_HALF      = 3'h4
   } mapper_e;
   typedef enum logic [0:0] {
      FUSE_IDLE = 1'b0,
      FUSE_LOAD = 1'b1
   } fuse_state_e;
endpackage
`default_nettype wire

/* hdl/cfg_serial_port.sv */
/*
 Serial configuration port: 16-bit frames, read flag, 7-bit address, 8 data
 bits, most significant first; sampled on rising serial clock.
 Assumes the serial pins are synchronous to clk_sys and far slower than it.
*/
`include "output_if_cfg.svh"
`default_nettype none
module cfg_serial_port
   import output_if_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Serial pins
   input  wire logic       sen_n,
   input  wire logic       sclk,
   input  wire logic       sdi,
   output logic            sdo,
   output logic            sdo_oe,
   // Register access
   output logic [6:0]      addr,
   output logic [7:0]      wdata,
   output logic            wr_stb,
   input  wire logic [7:0] rdata
);
   logic        sclk_q, sclk_d;
   logic [4:0]  cnt_q, cnt_d;
   logic [15:0] sh_q, sh_d;
   logic [7:0]  out_q, out_d;
   logic        sdo_q, sdo_d;
   logic        oe_q, oe_d;
   logic        wr_q, wr_d;

   always_comb begin
      sclk_d = sclk;
      cnt_d  = cnt_q;
      sh_d   = sh_q;
      out_d  = out_q;
      sdo_d  = sdo_q;
      oe_d   = oe_q;
      wr_d   = 1'b0;
      if (sen_n) begin
         cnt_d = 5'h00;
         oe_d  = 1'b0;
      end else if (sclk && !sclk_q && cnt_q != `FRAME_BITS) begin
         sh_d  = {sh_q[14:0], sdi};
         cnt_d = cnt_q + 5'h01;
         wr_d  = (cnt_q == `FRAME_BITS - 5'h01) && !sh_q[14];
      end else if (!sclk && sclk_q && sh_q[7] && cnt_q == `ADDR_PHASE_BITS) begin
         out_d = rdata;
         sdo_d = rdata[7];
         oe_d  = 1'b1;
      end else if (!sclk && sclk_q && oe_q) begin
         out_d = {out_q[6:0], 1'b0};
         sdo_d = out_q[6];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sclk_q <= 1'b0;
         cnt_q  <= 5'h00;
         sh_q   <= 16'h0000;
         out_q  <= 8'h00;
         sdo_q  <= 1'b0;
         oe_q   <= 1'b0;
         wr_q   <= 1'b0;
      end else begin
         sclk_q <= sclk_d;
         cnt_q  <= cnt_d;
         sh_q   <= sh_d;
         out_q  <= out_d;
         sdo_q  <= sdo_d;
         oe_q   <= oe_d;
         wr_q   <= wr_d;
      end
   end

   assign addr   = wr_q ? sh_q[14:8] : sh_q[6:0];
   assign wdata  = sh_q[7:0];
   assign wr_stb = wr_q;
   assign sdo    = sdo_q;
   assign sdo_oe = oe_q;
endmodule
`default_nettype wire

/* hdl/fuse_loader.sv */
/*
 Fuse load sequencer: runs once on its own after reset and again on each
 start pulse seen while idle; busy while loading, done for one cycle at the end.
 Assumes start is a one-cycle pulse.
*/
`include "output_if_cfg.svh"
`default_nettype none
module fuse_loader
   import output_if_pkg::*;
#(
   parameter int unsigned LOAD_CYCLES = `FUSE_LOAD_CYCLES
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // Control
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   fuse_state_e state_q, state_d;
   logic [7:0]  cnt_q, cnt_d;
   logic        done_q, done_d;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      done_d  = 1'b0;
      case (state_q)
         FUSE_IDLE: begin
            if (start) begin
               state_d = FUSE_LOAD;
               cnt_d   = 8'h00;
            end
         end
         FUSE_LOAD: begin
            if (cnt_q == 8'(LOAD_CYCLES - 1)) begin
               state_d = FUSE_IDLE;
               done_d  = 1'b1;
            end else begin
               cnt_d = cnt_q + 8'h01;
            end
         end
         default: state_d = FUSE_IDLE;
      endcase
   end

   // Reset lands in the load state so the default variant loads unasked
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= FUSE_LOAD; // RQ4
         cnt_q   <= 8'h00;
         done_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         done_q  <= done_d;
      end
   end

   assign busy = (state_q == FUSE_LOAD);
   assign done = done_q;
endmodule
`default_nettype wire

/* hdl/output_if_and_powerdown_regs.sv */
/*
 Output interface and power-down register group of a dual-channel converter,
 reached over the serial configuration port. Holds the interface, power and
 buffer disable registers, plus the soft reset and fuse load command bits.
 Assumes the global power-down mask arrives on pdn_mask from its own register.
*/
`include "output_if_cfg.svh"
`default_nettype none
module output_if_and_powerdown_regs
   import output_if_pkg::*;
#(
   parameter int unsigned LOAD_CYCLES = `FUSE_LOAD_CYCLES,
   parameter logic [2:0]  FUSE_MAPPER = `FUSE_MAPPER_DEF,
   parameter logic [2:0]  FUSE_MODE   = `FUSE_MODE_DEF
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // Serial configuration pins
   input  wire logic        sen_n,
   input  wire logic        sclk,
   input  wire logic        sdi,
   output logic             sdo,
   output logic             sdo_oe,
   // Global power-down mask
   input  wire logic [3:0]  pdn_mask,
   // Active interface settings
   output logic [2:0]       lane_bit_mapper,
   output logic [2:0]       lane_mode,
   output logic             fuse_busy,
   // Power-down controls
   output logic             sample_clock_buffer_off,
   output logic             reference_amp_off,
   output logic             channel_a_off,
   output logic             channel_b_off,
   output logic             whole_chip_sleep,
   output logic             bandgap_off,
   output logic [23:0]      output_buffer_disable_bits
);
   logic [6:0]  addr;
   logic [7:0]  wdata;
   logic        wr_stb;
   logic [7:0]  rdata;
   logic        sdo_w, sdo_oe_w;
   logic        load_busy, load_done;

   logic [7:0]  if_cfg_q, if_cfg_d;
   logic [7:0]  pwr_q, pwr_d;
   logic        written_q, written_d;
   logic        fuse_start_q, fuse_start_d;
   logic        soft_rst_q, soft_rst_d;
   logic        cfg_clear;
   logic [7:0]  obd_q [3];
   logic [7:0]  obd_d [3];

   logic [2:0]  mapper_q, mapper_d;
   logic [2:0]  mode_q, mode_d;
   logic        busy_q;
   logic        clkbuf_q, clkbuf_d;
   logic        refamp_q, refamp_d;
   logic        cha_q, cha_d;
   logic        chb_q, chb_d;
   logic        sleep_q, sleep_d;
   logic        bg_q, bg_d;
   logic        sdo_q, sdo_oe_q;
   logic [2:0]  map_field;
   logic [2:0]  sel_field;
   logic        map_ok, sel_ok;

   cfg_serial_port u_port (
      .clk_sys (clk_sys),
      .rst     (rst),
      .sen_n   (sen_n),
      .sclk    (sclk),
      .sdi     (sdi),
      .sdo     (sdo_w),
      .sdo_oe  (sdo_oe_w),
      .addr    (addr),
      .wdata   (wdata),
      .wr_stb  (wr_stb),
      .rdata   (rdata)
   );

   fuse_loader #(
      .LOAD_CYCLES (LOAD_CYCLES)
   ) u_fuse (
      .clk_sys (clk_sys),
      .rst     (rst),
      .start   (fuse_start_q),
      .busy    (load_busy),
      .done    (load_done)
   );

   // Soft reset or fuse load wipes the earlier buffer disable writes
   assign cfg_clear = soft_rst_q | fuse_start_q; // RQ3

   always_comb begin
      if_cfg_d     = if_cfg_q;
      pwr_d        = pwr_q;
      written_d    = written_q;
      fuse_start_d = 1'b0;
      soft_rst_d   = 1'b0;
      if (soft_rst_q) begin
         if_cfg_d     = `REG_RESET;
         pwr_d        = `REG_RESET;
         written_d    = 1'b0;
         fuse_start_d = 1'b1;
      end else begin
         if (fuse_start_q) begin
            pwr_d = `REG_RESET;
         end
         if (wr_stb) begin
            case (addr)
               `ADDR_IF_CFG: begin
                  if_cfg_d  = wdata;
                  written_d = 1'b1; // RQ5
               end
               `ADDR_PWR:        pwr_d        = wdata;
               `ADDR_SOFT_RESET: soft_rst_d   = wdata[0];
               `ADDR_FUSE_CMD:   fuse_start_d = wdata[0]; // RQ2
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         if_cfg_q     <= `REG_RESET;
         pwr_q        <= `REG_RESET;
         written_q    <= 1'b0;
         fuse_start_q <= 1'b0;
         soft_rst_q   <= 1'b0;
      end else begin
         if_cfg_q     <= if_cfg_d;
         pwr_q        <= pwr_d;
         written_q    <= written_d;
         fuse_start_q <= fuse_start_d;
         soft_rst_q   <= soft_rst_d;
      end
   end

   // One buffer disable register per byte of the 24-bit field
   for (genvar i = 0; i < 3; i++) begin : g_obd
      always_comb begin
         obd_d[i] = obd_q[i];
         if (cfg_clear) begin
            obd_d[i] = `REG_RESET;
         end
         if (wr_stb && addr == 7'(`ADDR_OBD0 + i)) begin
            obd_d[i] = wdata; // RQ14
         end
      end
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            obd_q[i] <= `REG_RESET;
         end else begin
            obd_q[i] <= obd_d[i];
         end
      end
   end

   assign map_field = if_cfg_q[`IF_MAPPER_MSB:`IF_MAPPER_LSB];
   assign sel_field = if_cfg_q[`IF_SEL_MSB:`IF_SEL_LSB];
   assign map_ok    = map_field inside {MAP_TWO_18_14, MAP_TWO_20_16, MAP_ONE, MAP_HALF}; // RQ1
   assign sel_ok    = sel_field inside {LANE_TWO, LANE_ONE, LANE_HALF}; // RQ6

   // Unused codes fall back to the fuse defaults
   always_comb begin
      mapper_d = mapper_q;
      if (load_done) begin
         mapper_d = (written_q && map_ok) ? map_field : FUSE_MAPPER; // RQ2
      end
      mode_d = (if_cfg_q[`IF_OVR_EN_BIT] && sel_ok) ? sel_field : FUSE_MODE; // RQ7
      sleep_d  = pwr_q[`PWR_GLOBAL_BIT]; // RQ13
      clkbuf_d = pwr_q[`PWR_CLKBUF_BIT] | (sleep_d & ~pdn_mask[`MASK_CLKBUF_BIT]); // RQ9
      refamp_d = pwr_q[`PWR_REFAMP_BIT] | (sleep_d & ~pdn_mask[`MASK_REFAMP_BIT]); // RQ10
      cha_d    = pwr_q[`PWR_CHA_BIT] | sleep_d; // RQ11
      chb_d    = pwr_q[`PWR_CHB_BIT] | sleep_d; // RQ12
      bg_d     = sleep_d & pdn_mask[`MASK_BG_BIT];
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mapper_q <= FUSE_MAPPER;
         mode_q   <= FUSE_MODE;
         busy_q   <= 1'b1;
         clkbuf_q <= 1'b0;
         refamp_q <= 1'b0;
         cha_q    <= 1'b0;
         chb_q    <= 1'b0;
         sleep_q  <= 1'b0;
         bg_q     <= 1'b0;
         sdo_q    <= 1'b0;
         sdo_oe_q <= 1'b0;
      end else begin
         mapper_q <= mapper_d;
         mode_q   <= mode_d;
         busy_q   <= load_busy;
         clkbuf_q <= clkbuf_d;
         refamp_q <= refamp_d;
         cha_q    <= cha_d;
         chb_q    <= chb_d;
         sleep_q  <= sleep_d;
         bg_q     <= bg_d;
         sdo_q    <= sdo_w;
         sdo_oe_q <= sdo_oe_w;
      end
   end

   // Read-back shows the stored fields, not the fuse defaults in force
   always_comb begin
      case (addr)
         `ADDR_IF_CFG:   rdata = if_cfg_q; // RQ5
         `ADDR_PWR:      rdata = pwr_q;
         `ADDR_OBD0:     rdata = obd_q[0];
         `ADDR_OBD1:     rdata = obd_q[1];
         `ADDR_OBD2:     rdata = obd_q[2];
         `ADDR_FUSE_CMD: rdata = {7'h00, load_busy};
         default:        rdata = 8'h00;
      endcase
   end

   assign sdo                        = sdo_q;
   assign sdo_oe                     = sdo_oe_q;
   assign lane_bit_mapper            = mapper_q;
   assign lane_mode                  = mode_q;
   assign fuse_busy                  = busy_q;
   assign sample_clock_buffer_off    = clkbuf_q;
   assign reference_amp_off          = refamp_q;
   assign channel_a_off              = cha_q;
   assign channel_b_off              = chb_q;
   assign whole_chip_sleep           = sleep_q;
   assign bandgap_off                = bg_q;
   assign output_buffer_disable_bits = {obd_q[2], obd_q[1], obd_q[0]};

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_mid_write;
      wr_stb && addr == `ADDR_OBD1;
   endsequence
   sequence s_mid_lands;
      ##2 output_buffer_disable_bits[15:8] == $past(wdata, 2);
   endsequence
   // A load command on an idle loader must show up as busy
   sequence s_load_cmd;
      fuse_start_q && !load_busy;
   endsequence
   sequence s_load_runs;
      ##[1:2] fuse_busy;
   endsequence

   mapper_read_zero_a: assert property ( // RQ5
      (!written_q && addr == `ADDR_IF_CFG) |-> rdata[7:5] == 3'h0)
      else $error("mapper field reads nonzero before any write");
   mapper_hold_a: assert property ( // RQ2
      $changed(lane_bit_mapper) |-> $past(load_done))
      else $error("mapper changed without a fuse load");
   mapper_legal_a: assert property ( // RQ1
      lane_bit_mapper inside {MAP_TWO_18_14, MAP_TWO_20_16, MAP_ONE, MAP_HALF})
      else $error("active mapper holds an unused code");
   boot_load_a: assert property ( // RQ4
      fuse_busy |-> ##[0:20] !fuse_busy)
      else $error("fuse load did not finish in time");
   lane_legal_a: assert property ( // RQ6
      lane_mode inside {LANE_TWO, LANE_ONE, LANE_HALF})
      else $error("active lane mode holds an unused code");
   override_gate_a: assert property ( // RQ7
      !if_cfg_q[`IF_OVR_EN_BIT] |=> lane_mode == FUSE_MODE)
      else $error("lane mode overridden without enable");
   clkbuf_off_a: assert property ( // RQ9
      pwr_q[`PWR_CLKBUF_BIT] |=> sample_clock_buffer_off)
      else $error("clock buffer left on");
   refamp_on_a: assert property ( // RQ10
      (!pwr_q[`PWR_REFAMP_BIT] && !pwr_q[`PWR_GLOBAL_BIT]) |=> !reference_amp_off)
      else $error("reference amplifier off without cause");
   chan_a_off_a: assert property ( // RQ11
      pwr_q[`PWR_CHA_BIT] |=> channel_a_off)
      else $error("channel A left on");
   chan_b_on_a: assert property ( // RQ12
      (!pwr_q[`PWR_CHB_BIT] && !pwr_q[`PWR_GLOBAL_BIT]) |=> !channel_b_off)
      else $error("channel B off without cause");
   sleep_mask_a: assert property ( // RQ13
      (pwr_q[`PWR_GLOBAL_BIT] && pdn_mask[`MASK_CLKBUF_BIT] && !pwr_q[`PWR_CLKBUF_BIT])
      |=> whole_chip_sleep && !sample_clock_buffer_off)
      else $error("masked clock buffer went off in sleep");
   buffer_write_a: assert property ( // RQ14
      s_mid_write |-> s_mid_lands)
      else $error("buffer disable byte not stored");
   clkbuf_on_a: assert property ( // RQ9
      (!pwr_q[`PWR_CLKBUF_BIT] && !pwr_q[`PWR_GLOBAL_BIT]) |=> !sample_clock_buffer_off)
      else $error("clock buffer off without cause");
   refamp_off_a: assert property ( // RQ10
      pwr_q[`PWR_REFAMP_BIT] |=> reference_amp_off)
      else $error("reference amplifier left on");
   chan_a_on_a: assert property ( // RQ11
      (!pwr_q[`PWR_CHA_BIT] && !pwr_q[`PWR_GLOBAL_BIT]) |=> !channel_a_off)
      else $error("channel A off without cause");
   chan_b_off_a: assert property ( // RQ12
      pwr_q[`PWR_CHB_BIT] |=> channel_b_off)
      else $error("channel B left on");
   sleep_all_a: assert property ( // RQ13
      pwr_q[`PWR_GLOBAL_BIT] |=> whole_chip_sleep && channel_a_off && channel_b_off)
      else $error("channels left on in sleep");
   override_take_a: assert property ( // RQ7
      (if_cfg_q[`IF_OVR_EN_BIT] && sel_ok) |=> lane_mode == $past(sel_field))
      else $error("enabled lane select not applied");
   mapper_load_a: assert property ( // RQ2
      (load_done && written_q && map_ok) |=> lane_bit_mapper == $past(map_field))
      else $error("written mapper not applied by fuse load");
   mapper_default_a: assert property ( // RQ4
      (load_done && !(written_q && map_ok)) |=> lane_bit_mapper == FUSE_MAPPER)
      else $error("fuse load did not restore default mapper");
   load_start_a: assert property ( // RQ2
      s_load_cmd |-> s_load_runs)
      else $error("fuse load command did not start a load");
endmodule
`default_nettype wire

/* verif/cfg_host_model.sv */
/*
 Serial configuration host: drives 16-bit frames (read flag, address, data,
 most significant bit first) and samples read data on sdo.
 Assumes clk_sys is the device clock; each sclk phase lasts 3 cycles.
*/
`default_nettype none
module cfg_host_model (
   // Clock
   input  wire logic clk_sys,
   // Serial pins
   output var logic  sen_n,
   output var logic  sclk,
   output var logic  sdi,
   input  wire logic sdo,
   input  wire logic sdo_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      sen_n = 1'b1;
      sclk  = 1'b0;
      sdi   = 1'b0;
   end

   // Output oe is high only if sdo_oe stood high at every data bit
   task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic oe);
      logic [15:0] f;
      f  = {rd, a, d};
      q  = 8'h00;
      oe = 1'b1;
      @(posedge clk_sys);
      #1;
      sen_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sclk = 1'b0;
         sdi  = f[i];
         repeat (3) @(posedge clk_sys);
         #1;
         if (i < 8) begin
            q[i] = sdo;
            oe   = oe & sdo_oe;
         end
         sclk = 1'b1;
         repeat (3) @(posedge clk_sys);
         #1;
      end
      // Released data line shows the inverse of its last bit
      sclk  = 1'b0;
      sdi   = ~sdi;
      sen_n = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
endmodule
`default_nettype wire

/* verif/output_if_and_powerdown_regs_test.sv */
/*
 Self-checking bench of the output interface and power-down register group.
 Assumes the host model on the serial pins and a shortened fuse load count.
*/
`default_nettype none
module output_if_and_powerdown_regs_test
   import output_if_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int         LOADS = 8;
   localparam logic [2:0] FMAP  = 3'h2;
   localparam logic [2:0] FMODE = 3'h3;

   logic        clk_sys, rst, sen_n, sclk, sdi, sdo, sdo_oe;
   logic [3:0]  pdn_mask;
   logic [2:0]  lane_bit_mapper, lane_mode;
   logic        fuse_busy, clk_off, ref_off, cha_off, chb_off, sleep, bg_off;
   logic [23:0] obd;
   logic [5:0]  pwr_pins;
   int          n_errors, checked, act_map;
   int          regs [0:31];
   logic [31:0] seed = 32'h2C96;

   assign pwr_pins = {clk_off, ref_off, cha_off, chb_off, sleep, bg_off};

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   output_if_and_powerdown_regs #(
      .LOAD_CYCLES(LOADS),
      .FUSE_MAPPER(FMAP),
      .FUSE_MODE  (FMODE)
   ) u_dut (
      .clk_sys(clk_sys), .rst(rst), .sen_n(sen_n), .sclk(sclk), .sdi(sdi),
      .sdo(sdo), .sdo_oe(sdo_oe), .pdn_mask(pdn_mask),
      .lane_bit_mapper(lane_bit_mapper), .lane_mode(lane_mode), .fuse_busy(fuse_busy),
      .sample_clock_buffer_off(clk_off), .reference_amp_off(ref_off),
      .channel_a_off(cha_off), .channel_b_off(chb_off), .whole_chip_sleep(sleep),
      .bandgap_off(bg_off), .output_buffer_disable_bits(obd)
   );

   cfg_host_model u_host (
      .clk_sys(clk_sys), .sen_n(sen_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe)
   );

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic int lane_exp();
      int s;
      s = regs[7] & 7;
      return ((regs[7] & 8) != 0 && s >= 3 && s <= 5) ? s : int'(FMODE);
   endfunction

   // Order: clock buffer, reference amp, channel A, channel B, sleep, bandgap
   function automatic int pwr_exp();
      int b, m, g;
      b = regs[8];
      m = pdn_mask;
      g = b & 1;
      return (((b >> 5 | g & ~m >> 3) & 1) << 5) | (((b >> 4 | g & ~m >> 2) & 1) << 4)
           | (((b >> 2 | g) & 1) << 3) | (((b >> 1 | g) & 1) << 2) | (g << 1) | (g & m >> 1);
   endfunction

   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic cmp_reg(input logic [7:0] got, input int exp);
      checked++;
      if (got !== exp[7:0]) begin
         n_errors++;
         $display("CHECK FAILED at %0t: read %h, expected %h", $time, got, exp[7:0]);
      end
   endtask

   task automatic cmp_pin(input logic [23:0] got, input int exp);
      checked++;
      if (got !== exp[23:0]) begin
         n_errors++;
         $display("CHECK FAILED at %0t: pins %h, expected %h", $time, got, exp[23:0]);
      end
   endtask

   task automatic wr(input int a, input int d);
      logic [7:0] q;
      logic       oe;
      u_host.xfer(1'b0, a[6:0], d[7:0], q, oe);
      if (a == 7 || a == 8 || (a >= 10 && a <= 12)) begin
         regs[a] = d & 255;
      end
   endtask

   task automatic rd(input int a, input int exp);
      logic [7:0] q;
      logic       oe;
      u_host.xfer(1'b1, a[6:0], 8'h00, q, oe);
      cmp_reg(q, exp);
      cmp_pin({23'h0, oe}, 1);
   endtask

   // Busy rises a few edges after the command, so let it appear first
   task automatic wait_idle();
      int n;
      n = 0;
      repeat (4) @(posedge clk_sys);
      #1;
      while (fuse_busy !== 1'b0) begin
         @(posedge clk_sys);
         #1;
         n++;
         if (n > 200) begin
            n_errors++;
            $display("CHECK FAILED at %0t: fuse load never ends", $time);
            summarize();
         end
      end
      repeat (3) @(posedge clk_sys);
      #1;
   endtask

   task automatic check_all();
      cmp_pin({18'h0, lane_bit_mapper, lane_mode}, act_map << 3 | lane_exp());
      cmp_pin({18'h0, pwr_pins}, pwr_exp());
      cmp_pin(obd, regs[12] << 16 | regs[11] << 8 | regs[10]);
      rd(7, regs[7]);
      rd(8, regs[8]);
      for (int a = 10; a <= 12; a++) rd(a, regs[a]);
   endtask

   initial begin
      int mp [6] = '{1, 2, 3, 4, 5, 0};
      int sl [6] = '{3, 4, 5, 6, 3, 4};
      int en [6] = '{1, 1, 1, 1, 0, 1};
      int v;
      rst      = 1'b1;
      pdn_mask = 4'h0;
      n_errors = 0;
      checked  = 0;
      act_map  = FMAP;
      regs     = '{default: 0};
      repeat (4) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      wait_idle();
      check_all();
      wr(5, 32'hFF);
      rd(5, 0);
      rd(19, 0);
      $display("test reset defaults done");
      for (int i = 0; i < 10; i++) begin
         pdn_mask = 4'(rnd());
         v = (rnd() & 32'h36) | (i & 1);
         wr(8, v);
         check_all();
      end
      // Sleep with clock buffer, amplifier and bandgap masks all set
      pdn_mask = 4'hE;
      wr(8, 1);
      check_all();
      $display("test power controls done");
      for (int k = 0; k < 6; k++) begin
         v = mp[k] << 5 | en[k] << 3 | sl[k];
         wr(7, v);
         cmp_pin({18'h0, lane_bit_mapper, lane_mode}, act_map << 3 | lane_exp());
         wr(19, 1);
         wait_idle();
         act_map = (mp[k] >= 1 && mp[k] <= 4) ? mp[k] : int'(FMAP);
         regs[8]  = 0;
         regs[10] = 0;
         regs[11] = 0;
         regs[12] = 0;
         check_all();
         for (int a = 10; a <= 12; a++) wr(a, rnd() & 32'hFF);
         check_all();
      end
      $display("test interface modes done");
      // Soft reset clears every register and reloads the fuse defaults
      wr(0, 1);
      act_map = FMAP;
      regs    = '{default: 0};
      wait_idle();
      check_all();
      $display("test soft reset done");
      summarize();
   end
endmodule
`default_nettype wire
